/* rtl/ma_cmd.sv */
/*
 * Query interpreter for a field-bus slave node: checks function code, quantity
 * and address, launches the access, bounds its processing time, then spaces the
 * response and the next query. Assumes a framer in the same clock domain that
 * delivers decoded queries and reports when the response has been sent.
 */
// Summary of operation
// - Transmit delay is configurable, five milliseconds by default.
// - Non position-table accesses finish within one millisecond.
// - One table entry: read 4 ms, write 15 ms, read and write 18 ms.
// - Two or more table entries: read 9 ms, write 90 ms, read and write 98 ms.
// - Word registers lie between 0500 and 9908, whole sixteen-bit words.
// - Word access uses codes 03 read, 06 single write, 10 multiple write.
// - Coils live at 0100 to 043F and are written with code 05.
// - Reserved gaps, below 0500 and above 9908, are never served.
// - Addresses 0500 to 0505 hold the latest alarm details.
// - Addresses 0D00 to 0D03 are the I/O control group.
// - Addresses 1000 to 3FFF are the slow position table, optional.
// - Addresses 8400 to 842E are maintenance data, optional.
// - Addresses 9000 to 9015 are the monitor group.
// - Response starts only after the transmit delay from the query.
// - Next query is accepted one millisecond after a response ends.
module ma_cmd #(
   parameter int unsigned CYC_PER_MS = ma_pkg::CYC_PER_MS,
   parameter bit          HAS_POS    = 1'b1,
   parameter bit          HAS_MAINT  = 1'b1
) (
   input  wire logic            core_clk_i,
   input  wire logic            srst_i,
   input  wire logic            query_valid_i,
   input  wire logic [7:0]      query_fc_i,
   input  wire logic [15:0]     query_addr_i,
   input  wire logic [15:0]     query_qty_i,
   input  wire logic            query_bcast_i,
   input  wire logic [7:0]      tx_delay_ms_i,
   input  wire logic            acc_done_i,
   input  wire logic            resp_done_i,
   output logic                 query_ready_o,
   output logic                 acc_start_o,
   output ma_pkg::ma_area_t     acc_area_o,
   output logic                 acc_read_o,
   output logic                 acc_write_o,
   output logic [15:0]          acc_addr_o,
   output logic [15:0]          acc_qty_o,
   output logic                 resp_start_o,
   output logic [7:0]           resp_exc_o,
   output logic                 tx_en_o
);

   localparam int DW = $clog2(CYC_PER_MS);

   // ----------------------------------------------------------------------
   // Query decode
   // ----------------------------------------------------------------------
   ma_pkg::ma_area_t lo_area, hi_area;
   logic             lo_legal, hi_legal;

   wire fc_rd   = query_fc_i == ma_pkg::FC_RD_HOLD;
   wire fc_w1   = query_fc_i == ma_pkg::FC_WR_SINGLE;
   wire fc_wm   = query_fc_i == ma_pkg::FC_WR_MULTI;
   wire fc_rw   = query_fc_i == ma_pkg::FC_RW_MULTI;
   wire fc_coil = query_fc_i == ma_pkg::FC_WR_COIL;
   wire fc_ok   = fc_rd | fc_w1 | fc_wm | fc_rw | fc_coil;
   wire [15:0] last_addr = 16'(query_addr_i + query_qty_i - 16'h0001);
   wire one_only = fc_w1 | fc_coil;
   wire qty_ok  = one_only ? query_qty_i == 16'h0001
                           : query_qty_i != 16'h0000 && query_qty_i <= ma_pkg::MAX_WORDS;
   // Whole span must stay inside one area, no wrap
   wire addr_ok = lo_legal && hi_legal && lo_area == hi_area && last_addr >= query_addr_i;
   wire rw_pos  = fc_rw && lo_area != ma_pkg::AREA_POS;
   wire [7:0] exc_nxt = !fc_ok || rw_pos ? ma_pkg::EXC_FUNC
                      : !qty_ok          ? ma_pkg::EXC_VALUE
                      : !addr_ok         ? ma_pkg::EXC_ADDR
                      : ma_pkg::EXC_NONE;

   ma_addr_dec #(.HAS_POS(HAS_POS), .HAS_MAINT(HAS_MAINT)) u_dec_lo (
      .addr_i  (query_addr_i),
      .coil_i  (fc_coil),
      .area_o  (lo_area),
      .legal_o (lo_legal)
   );

   ma_addr_dec #(.HAS_POS(HAS_POS), .HAS_MAINT(HAS_MAINT)) u_dec_hi (
      .addr_i  (last_addr),
      .coil_i  (fc_coil),
      .area_o  (hi_area),
      .legal_o (hi_legal)
   );

   // Processing budget by area, entry count and direction
   wire [15:0] entries = 16'((query_qty_i + ma_pkg::ENTRY_WORDS - 16'h0001) >> 4);
   wire multi = entries > 16'h0001;
   wire [7:0] pos_ms = fc_rw ? (multi ? ma_pkg::POS9_RW_MS : ma_pkg::POS1_RW_MS)
                     : fc_rd ? (multi ? ma_pkg::POS9_RD_MS : ma_pkg::POS1_RD_MS)
                     :         (multi ? ma_pkg::POS9_WR_MS : ma_pkg::POS1_WR_MS);
   wire [7:0] budget_nxt = lo_area == ma_pkg::AREA_POS ? pos_ms : ma_pkg::PROC_REG_MS;
   // Zero selects the default transmit delay
   wire [7:0] tx_dly_nxt = tx_delay_ms_i == 8'h00 ? ma_pkg::TX_DLY_DEF_MS : tx_delay_ms_i;

   // ----------------------------------------------------------------------
   // Millisecond timebase, restarted at each query and response end
   // ----------------------------------------------------------------------
   ma_pkg::ma_state_t state_q, state_d;
   logic [DW-1:0]     div_q;
   logic [7:0]        el_q, budget_q, tx_dly_q;
   logic              bcast_q, acc_start_q, resp_start_q;
   logic [7:0]        exc_q;
   ma_pkg::ma_area_t  area_q;
   logic              rd_q, wr_q;
   logic [15:0]       addr_q, qty_q;

   wire accept   = state_q == ma_pkg::S_IDLE && query_valid_i;
   wire restart  = accept || (state_q == ma_pkg::S_SEND && resp_done_i);
   wire tick     = div_q == DW'(CYC_PER_MS - 1);
   wire budget_up = el_q >= budget_q;
   wire dly_up   = el_q >= tx_dly_q;
   wire guard_up = el_q >= ma_pkg::GUARD_MS;

   // Divider and elapsed-ms counter (saturating)
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i || restart || tick)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
      if (srst_i || restart)
         el_q <= 8'h00;
      else if (tick && el_q != 8'hFF)
         el_q <= el_q + 8'h01;
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ma_pkg::S_IDLE:
            if (query_valid_i)
               state_d = exc_nxt != ma_pkg::EXC_NONE
                       ? (query_bcast_i ? ma_pkg::S_GUARD : ma_pkg::S_WAIT)
                       : ma_pkg::S_EXEC;
         ma_pkg::S_EXEC:
            if (acc_done_i || budget_up)
               state_d = bcast_q ? ma_pkg::S_GUARD : ma_pkg::S_WAIT;
         ma_pkg::S_WAIT:
            if (dly_up)
               state_d = ma_pkg::S_SEND;
         ma_pkg::S_SEND:
            if (resp_done_i)
               state_d = ma_pkg::S_GUARD;
         ma_pkg::S_GUARD:
            if (guard_up && !restart)
               state_d = ma_pkg::S_IDLE;
      endcase
   end

   // State, access start and response start pulses
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
         state_q <= ma_pkg::S_IDLE;
      else
         state_q <= state_d;
      acc_start_q  <= !srst_i && accept && exc_nxt == ma_pkg::EXC_NONE;
      resp_start_q <= !srst_i && state_q == ma_pkg::S_WAIT && dly_up;
   end

   // Query capture and late-processing failure
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         exc_q    <= ma_pkg::EXC_NONE;
         budget_q <= ma_pkg::PROC_REG_MS;
         tx_dly_q <= ma_pkg::TX_DLY_DEF_MS;
         bcast_q  <= 1'b0;
      end
      else if (accept)
      begin
         exc_q    <= exc_nxt;
         budget_q <= budget_nxt;
         tx_dly_q <= tx_dly_nxt;
         bcast_q  <= query_bcast_i;
      end
      else if (state_q == ma_pkg::S_EXEC && budget_up && !acc_done_i)
         exc_q    <= ma_pkg::EXC_FAIL;
   end

   // Access descriptor held for the back end
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         area_q <= ma_pkg::AREA_NONE;
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
         addr_q <= 16'h0000;
         qty_q  <= 16'h0000;
      end
      else if (accept)
      begin
         area_q <= lo_area;
         rd_q   <= fc_rd | fc_rw;
         wr_q   <= fc_w1 | fc_wm | fc_rw | fc_coil;
         addr_q <= query_addr_i;
         qty_q  <= query_qty_i;
      end
   end

   // Outputs
   assign query_ready_o = state_q == ma_pkg::S_IDLE;
   assign acc_start_o   = acc_start_q;
   assign acc_area_o    = area_q;
   assign acc_read_o    = rd_q;
   assign acc_write_o   = wr_q;
   assign acc_addr_o    = addr_q;
   assign acc_qty_o     = qty_q;
   assign resp_start_o  = resp_start_q;
   assign resp_exc_o    = exc_q;
   assign tx_en_o       = state_q == ma_pkg::S_SEND;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   a_exec_budget: assert property (state_q == ma_pkg::S_EXEC |-> el_q <= budget_q)
      else $error("processing ran past its budget");
   a_pos_single: assert property (accept && lo_area == ma_pkg::AREA_POS && fc_rd && !multi
                                  |=> budget_q == 8'h04)
      else $error("single entry read budget wrong");
   a_pos_multi: assert property (accept && lo_area == ma_pkg::AREA_POS && fc_wm && multi
                                 |=> budget_q == 8'h5A)
      else $error("multi entry write budget wrong");
   a_tx_delay: assert property ($rose(tx_en_o) |-> el_q >= tx_dly_q && !bcast_q)
      else $error("transmitter enabled early");
   a_dly_default: assert property (accept && tx_delay_ms_i == 8'h00 |=> tx_dly_q == 8'h05)
      else $error("default transmit delay wrong");
   a_guard_ready: assert property ($fell(tx_en_o) |-> !query_ready_o ##1 !query_ready_o)
      else $error("query accepted too soon after response");
   a_reserved_exc: assert property (accept && fc_rd && qty_ok && !lo_legal
                                    |=> resp_exc_o == 8'h02 && !acc_start_o)
      else $error("reserved address not refused");
   a_func_exc: assert property (accept && !fc_ok |=> resp_exc_o == 8'h01 && !acc_start_o)
      else $error("unsupported code not refused");
   a_word_span: assert property (accept && !fc_coil && lo_legal
                                 |-> query_addr_i >= 16'h0500 && query_addr_i <= 16'h9908)
      else $error("word access outside register space");
   a_coil_map: assert property (accept && fc_coil && lo_legal |-> lo_area == ma_pkg::AREA_COIL)
      else $error("coil decoded to wrong area");
   a_alarm_area: assert property (query_addr_i == 16'h0503 && !fc_coil
                                  |-> lo_area == ma_pkg::AREA_ALARM)
      else $error("alarm block not decoded");
   a_mon_area: assert property (query_addr_i == 16'h9015 && !fc_coil |-> lo_area == ma_pkg::AREA_MON)
      else $error("monitor group not decoded");

   c_good_read:  cover property (accept && fc_rd && exc_nxt == ma_pkg::EXC_NONE ##[1:300] resp_start_o);
   c_exception:  cover property (accept && exc_nxt != ma_pkg::EXC_NONE ##[1:300] tx_en_o);
   c_late_fail:  cover property (state_q == ma_pkg::S_EXEC && budget_up && !acc_done_i);
   c_broadcast:  cover property (accept && query_bcast_i ##1 state_q == ma_pkg::S_EXEC);

endmodule

/* rtl/ma_pkg.sv */
/*
 * Constants and types shared by the query interpreter and its address decoder.
 * Assumes a 25 MHz core clock. All times are whole milliseconds.
 */
package ma_pkg;

   // ----------------------------------------------------------------------
   // Function codes and exception codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] FC_RD_HOLD   = 8'h03;
   localparam logic [7:0] FC_WR_COIL   = 8'h05;
   localparam logic [7:0] FC_WR_SINGLE = 8'h06;
   localparam logic [7:0] FC_WR_MULTI  = 8'h10;
   localparam logic [7:0] FC_RW_MULTI  = 8'h17;
   localparam logic [7:0] EXC_NONE     = 8'h00;
   localparam logic [7:0] EXC_FUNC     = 8'h01;
   localparam logic [7:0] EXC_ADDR     = 8'h02;
   localparam logic [7:0] EXC_VALUE    = 8'h03;
   localparam logic [7:0] EXC_FAIL     = 8'h04;

   // ----------------------------------------------------------------------
   // Address map (word addresses)
   // ----------------------------------------------------------------------
   localparam logic [15:0] A_COIL_LO   = 16'h0100;
   localparam logic [15:0] A_COIL_HI   = 16'h043F;
   localparam logic [15:0] A_ALARM_LO  = 16'h0500;
   localparam logic [15:0] A_ALARM_HI  = 16'h0505;
   localparam logic [15:0] A_IO_LO     = 16'h0D00;
   localparam logic [15:0] A_IO_HI     = 16'h0D03;
   localparam logic [15:0] A_POS_LO    = 16'h1000;
   localparam logic [15:0] A_POS_HI    = 16'h3FFF;
   localparam logic [15:0] A_MAINT_LO  = 16'h8400;
   localparam logic [15:0] A_MAINT_HI  = 16'h842E;
   localparam logic [15:0] A_MON_LO    = 16'h9000;
   localparam logic [15:0] A_MON_HI    = 16'h9015;
   localparam logic [15:0] A_POSCMD    = 16'h9800;
   localparam logic [15:0] A_NUM_LO    = 16'h9900;
   localparam logic [15:0] A_NUM_HI    = 16'h9908;
   localparam logic [15:0] MAX_WORDS   = 16'h007D;
   localparam logic [15:0] ENTRY_WORDS = 16'h0010;

   // ----------------------------------------------------------------------
   // Timing, in milliseconds, and the derived cycle count
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
   localparam logic [7:0]  PROC_REG_MS = 8'h01;
   localparam logic [7:0]  POS1_RD_MS  = 8'h04;
   localparam logic [7:0]  POS1_WR_MS  = 8'h0F;
   localparam logic [7:0]  POS1_RW_MS  = 8'h12;
   localparam logic [7:0]  POS9_RD_MS  = 8'h09;
   localparam logic [7:0]  POS9_WR_MS  = 8'h5A;
   localparam logic [7:0]  POS9_RW_MS  = 8'h62;
   localparam logic [7:0]  TX_DLY_DEF_MS = 8'h05;
   localparam logic [7:0]  GUARD_MS    = 8'h01;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      AREA_NONE, AREA_COIL, AREA_ALARM, AREA_IO, AREA_POS,
      AREA_MAINT, AREA_MON, AREA_POSCMD, AREA_NUMCMD
   } ma_area_t;

   typedef enum logic [2:0] {S_IDLE, S_EXEC, S_WAIT, S_SEND, S_GUARD} ma_state_t;

endpackage

/* rtl/ma_addr_dec.sv */
/*
 * Address decoder: maps one word or coil address onto a functional area.
 * Purely combinational; the caller picks coil or word space by function code.
 */
module ma_addr_dec #(
   parameter bit HAS_POS   = 1'b1,
   parameter bit HAS_MAINT = 1'b1
) (
   input  wire logic [15:0]     addr_i,
   input  wire logic            coil_i,
   output ma_pkg::ma_area_t     area_o,
   output logic                 legal_o
);

   // ----------------------------------------------------------------------
   // Range matches
   // ----------------------------------------------------------------------
   wire in_coil  = addr_i >= ma_pkg::A_COIL_LO  && addr_i <= ma_pkg::A_COIL_HI;
   wire in_alarm = addr_i >= ma_pkg::A_ALARM_LO && addr_i <= ma_pkg::A_ALARM_HI;
   wire in_io    = addr_i >= ma_pkg::A_IO_LO    && addr_i <= ma_pkg::A_IO_HI;
   wire in_pos   = HAS_POS && addr_i >= ma_pkg::A_POS_LO && addr_i <= ma_pkg::A_POS_HI;
   wire in_maint = HAS_MAINT && addr_i >= ma_pkg::A_MAINT_LO && addr_i <= ma_pkg::A_MAINT_HI;
   wire in_mon   = addr_i >= ma_pkg::A_MON_LO   && addr_i <= ma_pkg::A_MON_HI;
   wire in_pcmd  = addr_i == ma_pkg::A_POSCMD;
   wire in_num   = addr_i >= ma_pkg::A_NUM_LO   && addr_i <= ma_pkg::A_NUM_HI;

   // Area select; anything unmatched is a reserved gap
   assign area_o = coil_i   ? (in_coil ? ma_pkg::AREA_COIL : ma_pkg::AREA_NONE)
                 : in_alarm ? ma_pkg::AREA_ALARM
                 : in_io    ? ma_pkg::AREA_IO
                 : in_pos   ? ma_pkg::AREA_POS
                 : in_maint ? ma_pkg::AREA_MAINT
                 : in_mon   ? ma_pkg::AREA_MON
                 : in_pcmd  ? ma_pkg::AREA_POSCMD
                 : in_num   ? ma_pkg::AREA_NUMCMD
                 : ma_pkg::AREA_NONE;
   assign legal_o = area_o != ma_pkg::AREA_NONE;

endmodule

/* test/ma_far_model.sv */
/*
 * Far-side model: a back end that finishes each access and a framer that sends each response.
 * Assumes the interpreter's clock and synchronous reset; all delays are counted in clock cycles.
 */
module ma_far_model (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        acc_start_i,
   input  wire logic        resp_start_i,
   input  wire logic [15:0] done_dly_i,
   input  wire logic [7:0]  resp_len_i,
   output logic             acc_done_o,
   output logic             resp_done_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] acc_cnt_q;
   logic        acc_busy_q;
   logic [7:0]  resp_cnt_q;
   logic        resp_busy_q;

   // ----------------------------------------------------------------------
   // Back end and framer
   // ----------------------------------------------------------------------
   // Back end: done pulse a set number of cycles after launch; all ones answers only after 65535 cycles
   always_ff @(posedge core_clk_i)
   begin
      acc_done_o <= 1'b0;
      if (srst_i || acc_start_i)
      begin
         acc_busy_q <= !srst_i;
         acc_cnt_q  <= 16'h0001;
      end
      else if (acc_busy_q && acc_cnt_q == done_dly_i)
      begin
         acc_done_o <= 1'b1;
         acc_busy_q <= 1'b0;
      end
      else
         acc_cnt_q <= acc_cnt_q + 16'h0001;
   end

   // Framer: only a started response is ever finished, so broadcasts get no answer
   always_ff @(posedge core_clk_i)
   begin
      resp_done_o <= 1'b0;
      if (srst_i || resp_start_i)
      begin
         resp_busy_q <= !srst_i;
         resp_cnt_q  <= 8'h01;
      end
      else if (resp_busy_q && resp_cnt_q == resp_len_i)
      begin
         resp_done_o <= 1'b1;
         resp_busy_q <= 1'b0;
      end
      else
         resp_cnt_q <= resp_cnt_q + 8'h01;
   end
endmodule

/* test/ma_cmd_tb_top.sv */
/*
 * Self-checking bench for the query interpreter, with the far-side model answering.
 * Assumes the millisecond timebase is shortened to CPM cycles; inputs change on falling edges.
 */
module ma_cmd_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned CPM = 20;
   // Host side assumptions: response length, line rate and re-send count
   localparam int          RESP_BYTES = 8;
   localparam int          KBPS       = 10;
   localparam int          RETRIES    = 3;
   logic             core_clk_i    = 1'b0;
   logic             srst_i        = 1'b1;
   logic             query_valid_i = 1'b0;
   logic [7:0]       query_fc_i    = 8'h03;
   logic [15:0]      query_addr_i  = 16'h0000;
   logic [15:0]      query_qty_i   = 16'h0001;
   logic             query_bcast_i = 1'b0;
   logic [7:0]       tx_delay_ms_i = 8'h00;
   logic [15:0]      done_dly      = 16'h0003;
   logic             acc_done_i, resp_done_i, query_ready_o, acc_start_o;
   logic             acc_read_o, acc_write_o, resp_start_o, tx_en_o;
   int               tx_hits       = 0;
   ma_pkg::ma_area_t acc_area_o;
   logic [15:0]      acc_addr_o, acc_qty_o;
   logic [7:0]       resp_exc_o;
   int               failures      = 0;
   int               check_count   = 0;

   // ----------------------------------------------------------------------
   // Clock, monitor and instances
   // ----------------------------------------------------------------------
   // Clock at 25 MHz
   always #20 core_clk_i = ~core_clk_i;
   // Counts cycles of transmitter activity
   always @(posedge core_clk_i)
      if (tx_en_o === 1'b1)
         tx_hits++;

   ma_cmd #(.CYC_PER_MS(CPM)) ma_cmd_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .query_valid_i(query_valid_i), .query_fc_i(query_fc_i), .query_addr_i(query_addr_i),
      .query_qty_i(query_qty_i), .query_bcast_i(query_bcast_i), .tx_delay_ms_i(tx_delay_ms_i),
      .acc_done_i(acc_done_i), .resp_done_i(resp_done_i), .query_ready_o(query_ready_o),
      .acc_start_o(acc_start_o), .acc_area_o(acc_area_o), .acc_read_o(acc_read_o),
      .acc_write_o(acc_write_o), .acc_addr_o(acc_addr_o), .acc_qty_o(acc_qty_o),
      .resp_start_o(resp_start_o), .resp_exc_o(resp_exc_o), .tx_en_o(tx_en_o));
   ma_far_model ma_far_model_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .acc_start_i(acc_start_o),
      .resp_start_i(resp_start_o), .done_dly_i(done_dly), .resp_len_i(8'h04),
      .acc_done_o(acc_done_i), .resp_done_o(resp_done_i));

   // ----------------------------------------------------------------------
   // Reporting and comparison
   // ----------------------------------------------------------------------
   task automatic close_out;
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_rng(input int n, input int lo, input int hi);
      check_count++;
      if (n < lo || n > hi)
      begin
         failures++;
         $display("[ERR] %0t took %0d cycles, expected %0d to %0d", $time, n, lo, hi);
      end
   endtask

   // One whole query: launch, then response timing, code and guard before the next one; a broadcast only checks the transmitter stays idle
   task automatic run_q(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q, input logic bc,
                        input logic [7:0] tx, input logic [15:0] dly, input ma_pkg::ma_area_t ar,
                        input logic [7:0] ex, input int lo);
      int   n;
      int   h0;
      int   tmo;
      logic go;
      go = (ex === ma_pkg::EXC_NONE) || (ex === ma_pkg::EXC_FAIL);
      // Host timeout: expected time tripled, plus transmit delay and byte term over the line rate
      tmo = (3 * (lo / CPM) + ((tx == 8'h00) ? int'(ma_pkg::TX_DLY_DEF_MS) : int'(tx))
             + 10 * (RESP_BYTES + 8) / KBPS) * CPM;
      h0 = tx_hits;
      query_fc_i = fc;
      query_addr_i = a;
      query_qty_i = q;
      query_bcast_i = bc;
      tx_delay_ms_i = tx;
      done_dly = dly;
      query_valid_i = 1'b1;
      @(negedge core_clk_i);
      query_valid_i = 1'b0;
      cmp_val(acc_start_o, go);
      if (go)
      begin
         cmp_val(acc_area_o, ar);
         cmp_val(acc_addr_o, a);
         cmp_val(acc_qty_o, q);
         cmp_val(acc_write_o, fc != 8'h03);
         cmp_val(acc_read_o, fc == 8'h03 || fc == 8'h17);
      end
      n = 1;
      // Re-sends meet a busy node, so the host waits out three more timeouts before giving up
      while (resp_start_o !== 1'b1 && query_ready_o !== 1'b1 && n < tmo * (1 + RETRIES))
      begin
         @(negedge core_clk_i);
         n++;
      end
      if (bc)
         cmp_val(16'(tx_hits - h0), 16'h0000);
      else
      begin
         cmp_rng(n, lo, lo + 5);
         cmp_val(tx_en_o, 1'b1);
         cmp_val(resp_exc_o, ex);
         while (tx_en_o !== 1'b0 && n < 6000)
         begin
            @(negedge core_clk_i);
            n++;
         end
         n = 0;
         while (query_ready_o !== 1'b1 && n < 100)
         begin
            @(negedge core_clk_i);
            n++;
         end
         cmp_rng(n, CPM - 2, CPM + 2);
      end
   endtask

   task automatic ask(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
                      input ma_pkg::ma_area_t ar, input logic [7:0] ex);
      run_q(fc, a, q, 1'b0, 8'h00, 16'h0003, ar, ex, 5 * CPM);
   endtask

   task automatic dec(input logic [15:0] a, input ma_pkg::ma_area_t ar);
      ask(8'h03, a, 16'h0001, ar, (ar == ma_pkg::AREA_NONE) ? ma_pkg::EXC_ADDR : ma_pkg::EXC_NONE);
   endtask

   task automatic slow(input logic [7:0] fc, input logic [15:0] q, input ma_pkg::ma_area_t ar, input int ms);
      run_q(fc, (ar == ma_pkg::AREA_POS) ? 16'h1000 : 16'h0500, q, 1'b0, 8'h01, 16'hFFFF, ar,
            ma_pkg::EXC_FAIL, ms * CPM);
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset;
      repeat (20) @(negedge core_clk_i);
      cmp_val(query_ready_o, 1'b1);
      cmp_val(tx_en_o, 1'b0);
      cmp_val(resp_exc_o, 8'h00);
      srst_i = 1'b0;
   endtask

   task automatic t_map;
      dec(16'h04FF, ma_pkg::AREA_NONE);
      dec(16'h0500, ma_pkg::AREA_ALARM);
      dec(16'h0505, ma_pkg::AREA_ALARM);
      dec(16'h0506, ma_pkg::AREA_NONE);
      dec(16'h0D00, ma_pkg::AREA_IO);
      dec(16'h0D03, ma_pkg::AREA_IO);
      dec(16'h0D04, ma_pkg::AREA_NONE);
      dec(16'h1000, ma_pkg::AREA_POS);
      dec(16'h3FFF, ma_pkg::AREA_POS);
      dec(16'h4000, ma_pkg::AREA_NONE);
      dec(16'h8400, ma_pkg::AREA_MAINT);
      dec(16'h842E, ma_pkg::AREA_MAINT);
      dec(16'h9000, ma_pkg::AREA_MON);
      dec(16'h9015, ma_pkg::AREA_MON);
      dec(16'h9800, ma_pkg::AREA_POSCMD);
      dec(16'h9900, ma_pkg::AREA_NUMCMD);
      dec(16'h9908, ma_pkg::AREA_NUMCMD);
      dec(16'h9909, ma_pkg::AREA_NONE);
   endtask

   task automatic t_codes;
      ask(8'h05, 16'h0100, 16'h0001, ma_pkg::AREA_COIL, ma_pkg::EXC_NONE);
      ask(8'h05, 16'h043F, 16'h0001, ma_pkg::AREA_COIL, ma_pkg::EXC_NONE);
      ask(8'h05, 16'h0440, 16'h0001, ma_pkg::AREA_NONE, ma_pkg::EXC_ADDR);
      ask(8'h06, 16'h0D00, 16'h0001, ma_pkg::AREA_IO, ma_pkg::EXC_NONE);
      ask(8'h06, 16'h0D00, 16'h0002, ma_pkg::AREA_IO, ma_pkg::EXC_VALUE);
      ask(8'h10, 16'h9000, 16'h0016, ma_pkg::AREA_MON, ma_pkg::EXC_NONE);
      ask(8'h10, 16'h9000, 16'h0017, ma_pkg::AREA_NONE, ma_pkg::EXC_ADDR);
      ask(8'h10, 16'h1000, 16'h007D, ma_pkg::AREA_POS, ma_pkg::EXC_NONE);
      ask(8'h03, 16'h0500, 16'h007E, ma_pkg::AREA_NONE, ma_pkg::EXC_VALUE);
      ask(8'h01, 16'h04FF, 16'h0001, ma_pkg::AREA_NONE, ma_pkg::EXC_FUNC);
      ask(8'h17, 16'h0500, 16'h0001, ma_pkg::AREA_NONE, ma_pkg::EXC_FUNC);
   endtask

   task automatic t_budget;
      slow(8'h03, 16'h0001, ma_pkg::AREA_ALARM, 1);
      slow(8'h03, 16'h0001, ma_pkg::AREA_POS, 4);
      slow(8'h06, 16'h0001, ma_pkg::AREA_POS, 15);
      slow(8'h17, 16'h0010, ma_pkg::AREA_POS, 18);
      slow(8'h03, 16'h0011, ma_pkg::AREA_POS, 9);
      slow(8'h10, 16'h0020, ma_pkg::AREA_POS, 90);
      slow(8'h17, 16'h0020, ma_pkg::AREA_POS, 98);
      run_q(8'h10, 16'h1000, 16'h0010, 1'b0, 8'h01, 16'(14 * CPM), ma_pkg::AREA_POS, ma_pkg::EXC_NONE,
            14 * CPM);
   endtask

   task automatic t_delay;
      run_q(8'h03, 16'h9000, 16'h0001, 1'b0, 8'h02, 16'h0003, ma_pkg::AREA_MON, ma_pkg::EXC_NONE,
            2 * CPM);
      run_q(8'h06, 16'h0D00, 16'h0001, 1'b1, 8'h00, 16'h0003, ma_pkg::AREA_IO, ma_pkg::EXC_NONE, 0);
      ask(8'h03, 16'h0500, 16'h0001, ma_pkg::AREA_ALARM, ma_pkg::EXC_NONE);
   endtask

   // Main sequence
   initial
   begin
      t_reset;
      t_map;
      t_codes;
      t_budget;
      t_delay;
      close_out;
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (40000) @(posedge core_clk_i);
      failures++;
      close_out;
   end
endmodule
